// ---- src/apc_pkg.sv ----
package apc_pkg;

    // ------------------------------------------------------------
    // Register indexes and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_CFG12    = 8'h59;
    localparam logic [7:0]  IDX_CFG3     = 8'h5A;
    localparam logic [7:0]  IDX_STATUS   = 8'h60;
    localparam logic [7:0]  IDX_IRQ_STAT = 8'h61;
    localparam logic [7:0]  IDX_IRQ_MASK = 8'h62;
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] ADDR_CFG12    = {2'h0, IDX_CFG12, 2'h0};
    localparam logic [11:0] ADDR_CFG3     = {2'h0, IDX_CFG3, 2'h0};
    localparam logic [11:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [11:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
    localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

    // ------------------------------------------------------------
    // Pin count and per-pin field positions
    // ------------------------------------------------------------
    localparam int          NUM_PINS    = 3;
    localparam int          PIN_FIELD_W = 4;
    localparam int          BIT_DIR     = 0;
    localparam int          BIT_POL     = 1;
    localparam int          BIT_EDGE    = 2;
    localparam int          BIT_OUT     = 3;
    localparam int          SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG12_RESET = 8'h00;
    localparam logic [3:0]  CFG3_RESET  = 4'h0;
    localparam logic [2:0]  MASK_RESET  = 3'h0;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Carried types
    // ------------------------------------------------------------
    typedef struct packed {
        logic out_level;
        logic edge_mode;
        logic high_true;
        logic is_output;
    } apc_pin_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } apc_wr_t;

endpackage

// ---- src/apc_pin_sense.sv ----
`timescale 1ns/1ps
module apc_pin_sense (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    // Pin and settings
    input  wire logic                  pin_in,
    input  wire apc_pkg::apc_pin_cfg_t cfg,
    input  wire logic                  status_read,
    // Results
    output logic                       state_bit,
    output logic                       true_rise
);

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    logic [apc_pkg::SYNC_STAGES-1:0] sync_reg;
    logic                            stable_reg;
    logic                            true_reg;
    logic                            sticky_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync_reg   <= '0;
            stable_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[apc_pkg::SYNC_STAGES-2:0], pin_in};
            if (sync_reg[1] == sync_reg[2]) begin
                stable_reg <= sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Polarity, level and sticky report
    // ------------------------------------------------------------
    wire level_true = (stable_reg == cfg.high_true) & ~cfg.is_output;
    wire sticky_next = level_true | (sticky_reg & ~status_read);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // Starts true so leaving reset never looks like a pin event
            true_reg   <= 1'b1;
            sticky_reg <= 1'b0;
            state_bit  <= 1'b0;
            true_rise  <= 1'b0;
        end else begin
            true_reg   <= level_true;
            sticky_reg <= sticky_next;
            true_rise  <= level_true & ~true_reg;
            // Clear lands on the capture edge, so no true spell is lost
            state_bit  <= cfg.edge_mode ? sticky_next : level_true;
        end
    end

endmodule // apc_pin_sense

// ---- src/aux_pin_config.sv ----
`timescale 1ns/1ps
module aux_pin_config (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // Power state from the USB core
    input  wire logic                        usb_suspend,
    // Auxiliary pins
    input  wire logic [apc_pkg::NUM_PINS-1:0] pin_in,
    output logic      [apc_pkg::NUM_PINS-1:0] pin_out,
    output logic      [apc_pkg::NUM_PINS-1:0] pin_oe,
    // Interrupt
    output logic                             irq,
    // AXI4-Lite write address
    input  wire logic [apc_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    // AXI4-Lite write response
    output logic      [1:0]                  s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [apc_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    // AXI4-Lite read data
    output logic      [31:0]                 s_axi_rdata,
    output logic      [1:0]                  s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]                  cfg12_reg;
    logic [3:0]                  cfg3_reg;
    logic [2:0]                  irq_stat_reg;
    logic [2:0]                  irq_mask_reg;
    apc_pkg::apc_wr_t            wr_reg;
    logic                        aw_held_reg;
    logic                        w_held_reg;
    logic                        status_rd;
    logic [apc_pkg::NUM_PINS-1:0] state_bits;
    logic [apc_pkg::NUM_PINS-1:0] rise_bits;

    // ------------------------------------------------------------
    // Per-pin settings
    // ------------------------------------------------------------
    apc_pkg::apc_pin_cfg_t pin_cfg [apc_pkg::NUM_PINS];

    assign pin_cfg[0] = cfg12_reg[apc_pkg::PIN_FIELD_W-1:0];
    assign pin_cfg[1] = cfg12_reg[2*apc_pkg::PIN_FIELD_W-1:apc_pkg::PIN_FIELD_W];
    assign pin_cfg[2] = cfg3_reg;

    // ------------------------------------------------------------
    // Pin sensing, one slice per pin
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < apc_pkg::NUM_PINS; gi++) begin : g_pin
            apc_pin_sense u_sense (
                .clock       (clock),
                .rst_n       (rst_n),
                .pin_in      (pin_in[gi]),
                .cfg         (pin_cfg[gi]),
                .status_read (status_rd),
                .state_bit   (state_bits[gi]),
                .true_rise   (rise_bits[gi])
            );

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    pin_out[gi] <= 1'b0;
                    pin_oe[gi]  <= 1'b0;
                end else begin
                    pin_out[gi] <= pin_cfg[gi].out_level;
                    pin_oe[gi]  <= pin_cfg[gi].is_output & ~usb_suspend;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Write channel decode
    // ------------------------------------------------------------
    wire aw_fire   = s_axi_awvalid & s_axi_awready;
    wire w_fire    = s_axi_wvalid & s_axi_wready;
    wire b_fire    = s_axi_bvalid & s_axi_bready;
    wire wr_do     = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire lane0     = wr_do & wr_reg.strb[0];
    wire wa_cfg12  = wr_reg.addr == apc_pkg::ADDR_CFG12;
    wire wa_cfg3   = wr_reg.addr == apc_pkg::ADDR_CFG3;
    wire wa_status = wr_reg.addr == apc_pkg::ADDR_STATUS;
    wire wa_istat  = wr_reg.addr == apc_pkg::ADDR_IRQ_STAT;
    wire wa_imask  = wr_reg.addr == apc_pkg::ADDR_IRQ_MASK;
    wire wa_hit    = wa_cfg12 | wa_cfg3 | wa_status | wa_istat | wa_imask;
    wire [7:0] wbyte = wr_reg.data[7:0];

    // Suspend strips the direction bits so pins come back as inputs
    wire [7:0] dir12_mask = 8'h11;
    wire [7:0] cfg12_wr   = (lane0 & wa_cfg12) ? wbyte : cfg12_reg;
    wire [7:0] cfg12_next = usb_suspend ? (cfg12_wr & ~dir12_mask) : cfg12_wr;
    wire [3:0] cfg3_wr    = (lane0 & wa_cfg3) ? wbyte[3:0] : cfg3_reg;
    wire [3:0] cfg3_next  = usb_suspend ? (cfg3_wr & 4'hE) : cfg3_wr;

    // Set wins over the write-one clear
    wire [2:0] istat_clr  = (lane0 & wa_istat) ? wbyte[2:0] : 3'h0;
    wire [2:0] istat_next = (irq_stat_reg & ~istat_clr) | rise_bits;

    // ------------------------------------------------------------
    // Read channel decode
    // ------------------------------------------------------------
    wire ar_fire   = s_axi_arvalid & s_axi_arready;
    wire r_fire    = s_axi_rvalid & s_axi_rready;
    wire ra_cfg12  = s_axi_araddr == apc_pkg::ADDR_CFG12;
    wire ra_cfg3   = s_axi_araddr == apc_pkg::ADDR_CFG3;
    wire ra_status = s_axi_araddr == apc_pkg::ADDR_STATUS;
    wire ra_istat  = s_axi_araddr == apc_pkg::ADDR_IRQ_STAT;
    wire ra_imask  = s_axi_araddr == apc_pkg::ADDR_IRQ_MASK;
    wire ra_hit    = ra_cfg12 | ra_cfg3 | ra_status | ra_istat | ra_imask;

    // Clear on the edge that captures the word: a pin true just before stays sticky
    assign status_rd = ar_fire & ra_status;

    wire [31:0] rd_mux =
        ra_cfg12  ? {24'h000000, cfg12_reg}        :
        ra_cfg3   ? {28'h0000000, cfg3_reg}        :
        ra_status ? {29'h00000000, state_bits}     :
        ra_istat  ? {29'h00000000, irq_stat_reg}   :
        ra_imask  ? {29'h00000000, irq_mask_reg}   :
                    32'h00000000;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg12_reg    <= apc_pkg::CFG12_RESET;
            cfg3_reg     <= apc_pkg::CFG3_RESET;
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= apc_pkg::MASK_RESET;
            irq          <= 1'b0;
        end else begin
            cfg12_reg    <= cfg12_next;
            cfg3_reg     <= cfg3_next;
            irq_stat_reg <= istat_next;
            if (lane0 & wa_imask) begin
                irq_mask_reg <= wbyte[2:0];
            end
            irq <= |(istat_next & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Write handshake
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            wr_reg        <= '0;
        end else begin
            if (aw_fire) begin
                s_axi_awready <= 1'b0;
                aw_held_reg   <= 1'b1;
                wr_reg.addr   <= s_axi_awaddr;
            end else if (b_fire) begin
                s_axi_awready <= 1'b1;
            end
            if (w_fire) begin
                s_axi_wready <= 1'b0;
                w_held_reg   <= 1'b1;
                wr_reg.data  <= s_axi_wdata;
                wr_reg.strb  <= s_axi_wstrb;
            end else if (b_fire) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_do) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= apc_pkg::RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wa_hit ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
        end else if (b_fire) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read handshake
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= apc_pkg::RESP_OKAY;
        end else begin
            if (ar_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= ra_hit ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
            end else if (r_fire) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b0;
            end
        end
    end

endmodule // aux_pin_config

// ---- bench/apc_pin_world.sv ----
`timescale 1ns/1ps
module apc_pin_world (
    // Pins of the block
    input  wire logic [apc_pkg::NUM_PINS-1:0] pin_out,
    input  wire logic [apc_pkg::NUM_PINS-1:0] pin_oe,
    // Levels the switches and sensors present
    input  wire logic [apc_pkg::NUM_PINS-1:0] ext_level,
    output logic      [apc_pkg::NUM_PINS-1:0] pin_in
);
    // Driven pins read back the driven level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // apc_pin_world

// ---- bench/apc_monitor.sv ----
`timescale 1ns/1ps
module apc_monitor (
    // Clock, reset, power
    input wire logic                          clock,
    input wire logic                          rst_n,
    input wire logic                          usb_suspend,
    // Pins
    input wire logic [apc_pkg::NUM_PINS-1:0]  pin_out,
    input wire logic [apc_pkg::NUM_PINS-1:0]  pin_oe,
    // Register bus
    input wire logic [apc_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input wire logic                          s_axi_awvalid,
    input wire logic                          s_axi_awready,
    input wire logic [31:0]                   s_axi_wdata,
    input wire logic                          s_axi_wvalid,
    input wire logic                          s_axi_wready,
    input wire logic [1:0]                    s_axi_bresp,
    input wire logic                          s_axi_bvalid,
    input wire logic                          s_axi_bready,
    input wire logic [apc_pkg::ADDR_W-1:0]    s_axi_araddr,
    input wire logic                          s_axi_arvalid,
    input wire logic                          s_axi_arready,
    input wire logic [31:0]                   s_axi_rdata,
    input wire logic [1:0]                    s_axi_rresp,
    input wire logic                          s_axi_rvalid,
    input wire logic                          s_axi_rready
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [apc_pkg::ADDR_W-1:0] wa_reg;
    logic [7:0]                 wd_reg;
    wire                        b_done = s_axi_bvalid && s_axi_bready && !usb_suspend;
    function automatic logic unmapped(input logic [apc_pkg::ADDR_W-1:0] a);
        return !(a inside {apc_pkg::ADDR_CFG12, apc_pkg::ADDR_CFG3, apc_pkg::ADDR_STATUS,
                           apc_pkg::ADDR_IRQ_STAT, apc_pkg::ADDR_IRQ_MASK});
    endfunction
    // Last accepted write, so the pins can be judged against it
    always_ff @(posedge clock) begin
        if (s_axi_awvalid && s_axi_awready) wa_reg <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd_reg <= s_axi_wdata[7:0];
    end
    pins_one_two_a: assert property (
        b_done && wa_reg == apc_pkg::ADDR_CFG12 |=> pin_oe[1:0] == {wd_reg[4], wd_reg[0]}
        && pin_out[1:0] == {wd_reg[7], wd_reg[3]}) else $error("pins 1 and 2 differ from config");
    pin_three_a: assert property (
        b_done && wa_reg == apc_pkg::ADDR_CFG3 |=> pin_oe[2] == wd_reg[0] && pin_out[2] == wd_reg[3])
        else $error("pin 3 differs from config");
    suspend_input_a: assert property (usb_suspend [*3] |-> pin_oe == '0)
        else $error("pin driven during suspend");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
    wr_resp_a: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp ==
        (unmapped(wa_reg) ? apc_pkg::RESP_SLVERR : apc_pkg::RESP_OKAY)) else $error("bad write response");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp)) else $error("read data dropped");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    bad_read_a: assert property (s_axi_arvalid && s_axi_arready && unmapped(s_axi_araddr)
        |=> s_axi_rresp == apc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule // apc_monitor

bind aux_pin_config apc_monitor u_mon (.clock, .rst_n, .usb_suspend, .pin_out, .pin_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic                         clock, rst_n, usb_suspend, irq;
    logic [apc_pkg::NUM_PINS-1:0] pin_in, pin_out, pin_oe, ext_level;
    logic [apc_pkg::ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
    logic [2:0]                   s_axi_awprot, s_axi_arprot;
    logic [31:0]                  s_axi_wdata, s_axi_rdata, seed, d, v;
    logic [3:0]                   s_axi_wstrb;
    logic [1:0]                   s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int   mismatches, tests_run, cycles, i;
    aux_pin_config i_aux_pin_config (.clock, .rst_n, .usb_suspend, .pin_in, .pin_out, .pin_oe, .irq,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    apc_pin_world i_apc_pin_world (.pin_out, .pin_oe, .ext_level, .pin_in);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] exp_oe(input logic [31:0] c);
        return {c[8], c[4], c[0]};
    endfunction
    function automatic logic [2:0] exp_out(input logic [31:0] c);
        return {c[11], c[7], c[3]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [1:0] er);
        logic aw_p;
        logic w_p;
        aw_p = 1'h1;
        w_p = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (aw_p || w_p) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            aw_p = aw_p && !s_axi_awready;
            w_p = w_p && !s_axi_wready;
        end
        do @(posedge clock); while (!s_axi_bvalid);
        s_axi_bready <= 1'h1;
        @(posedge clock);
        s_axi_bready <= 1'h0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] rv);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        // One idle cycle so the slave must hold its answer
        @(posedge clock);
        s_axi_rready <= 1'h1;
        do @(posedge clock); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    // Whole run needs about 330 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {rst_n, usb_suspend, ext_level, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        seed = 32'hB859;
        {mismatches, tests_run, cycles} = '0;
        repeat (5) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        rd(apc_pkg::ADDR_CFG12, apc_pkg::RESP_OKAY, v);
        chk("cfg12 reset", 32'(apc_pkg::CFG12_RESET), v);
        rd(apc_pkg::ADDR_CFG3, apc_pkg::RESP_OKAY, v);
        chk("cfg3 reset", 32'(apc_pkg::CFG3_RESET), v);
        chk("oe reset", 32'h0, 32'(pin_oe));
        rd(12'h000, apc_pkg::RESP_SLVERR, v);
        chk("unmapped rdata", 32'h0, v);
        wr(12'h3FC, 32'hFF, apc_pkg::RESP_SLVERR);
        // Status is read-only: the write is answered and has no effect
        wr(apc_pkg::ADDR_STATUS, 32'h7, apc_pkg::RESP_OKAY);
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'hFFF : rnd();
            wr(apc_pkg::ADDR_CFG12, {24'h0, d[7:0]}, apc_pkg::RESP_OKAY);
            wr(apc_pkg::ADDR_CFG3, {28'h0, d[11:8]}, apc_pkg::RESP_OKAY);
            @(posedge clock);
            chk("pin_oe", 32'(exp_oe(d)), 32'(pin_oe));
            chk("pin_out", 32'(exp_out(d)), 32'(pin_out));
        end
        $display("test outputs done");
        wr(apc_pkg::ADDR_CFG12, 32'hFF, apc_pkg::RESP_OKAY);
        usb_suspend <= 1'h1;
        repeat (4) @(posedge clock);
        chk("oe in suspend", 32'h0, 32'(pin_oe));
        rd(apc_pkg::ADDR_CFG12, apc_pkg::RESP_OKAY, v);
        chk("dir after suspend", 32'h0, v & 32'h11);
        usb_suspend <= 1'h0;
        $display("test suspend done");
        for (i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'h0 : rnd();
            wr(apc_pkg::ADDR_CFG12, {26'h0, d[1], 3'h0, d[0], 1'h0}, apc_pkg::RESP_OKAY);
            wr(apc_pkg::ADDR_CFG3, {30'h0, d[2], 1'h0}, apc_pkg::RESP_OKAY);
            ext_level <= d[5:3];
            repeat (10) @(posedge clock);
            rd(apc_pkg::ADDR_STATUS, apc_pkg::RESP_OKAY, v);
            // Concatenation keeps the inversion to three bits
            chk("level status", {29'h0, ~(d[5:3] ^ d[2:0])}, v);
        end
        $display("test level done");
        ext_level <= 3'h0;
        wr(apc_pkg::ADDR_CFG12, 32'h66, apc_pkg::RESP_OKAY);
        wr(apc_pkg::ADDR_CFG3, 32'h6, apc_pkg::RESP_OKAY);
        repeat (10) @(posedge clock);
        rd(apc_pkg::ADDR_STATUS, apc_pkg::RESP_OKAY, v);
        wr(apc_pkg::ADDR_IRQ_STAT, 32'h7, apc_pkg::RESP_OKAY);
        wr(apc_pkg::ADDR_IRQ_MASK, 32'h7, apc_pkg::RESP_OKAY);
        chk("irq idle", 32'h0, 32'(irq));
        ext_level <= 3'h7;
        repeat (10) @(posedge clock);
        ext_level <= 3'h0;
        repeat (10) @(posedge clock);
        chk("irq raised", 32'h1, 32'(irq));
        rd(apc_pkg::ADDR_IRQ_STAT, apc_pkg::RESP_OKAY, v);
        chk("irq status", 32'h7, v);
        rd(apc_pkg::ADDR_STATUS, apc_pkg::RESP_OKAY, v);
        chk("sticky status", 32'h7, v);
        rd(apc_pkg::ADDR_STATUS, apc_pkg::RESP_OKAY, v);
        chk("sticky cleared", 32'h0, v);
        wr(apc_pkg::ADDR_IRQ_MASK, 32'h0, apc_pkg::RESP_OKAY);
        @(posedge clock);
        chk("irq masked", 32'h0, 32'(irq));
        wr(apc_pkg::ADDR_IRQ_STAT, 32'h7, apc_pkg::RESP_OKAY);
        wr(apc_pkg::ADDR_IRQ_MASK, 32'h7, apc_pkg::RESP_OKAY);
        @(posedge clock);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("test sticky done");
        finish_test();
    end
endmodule // tb_top
